// ### common/cgsc_pkg.sv
// Constants and types of the clock generator configuration port
package cgsc_pkg;
  // Full 8-bit slave address pattern, direction bit included
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hD2;
  localparam int CMD_BYTE_MODE_BIT = 7;
  localparam logic [6:0] IDX_REG_A = 7'h00;
  localparam logic [6:0] IDX_REG_B = 7'h01;
  localparam logic [7:0] REG_COUNT = 8'h02;
  localparam logic [7:0] RST_REG_A = 8'hFF;
  localparam logic [7:0] RST_REG_B = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [3:0] RST_FREQ_SEL = 4'h0;
  // Bit positions of misc_output_enable_b
  localparam int B_STORAGE_VIDEO = 7;
  localparam int B_SEL_24_48 = 6;
  localparam int B_FIXED_48 = 5;
  localparam int B_REFERENCE_CLK2 = 4;
  localparam int B_REFERENCE_CLK1 = 3;
  localparam int B_REFERENCE_CLK0 = 2;
  localparam int B_CPU1 = 1;
  localparam int B_CPU0 = 0;

  typedef struct packed {
    logic [7:0] diff_output_enable_a;
    logic [7:0] misc_output_enable_b;
  } cgsc_regs_type;

  localparam cgsc_regs_type RST_REGS = '{RST_REG_A, RST_REG_B};

  typedef struct packed {
    logic [6:0] idx;
    logic [7:0] data;
  } cgsc_wr_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK
  } cgsc_state_type;

  typedef enum logic [1:0] {
    PH_ADDR, PH_CMD, PH_CNT, PH_DATA
  } cgsc_phase_type;
endpackage : cgsc_pkg

// ### rtl/cgsc_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module cgsc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q_ff
);
  logic [WIDTH-1:0] meta_ff;

  if (WIDTH < 1) begin : g_bad_width
    $error("cgsc_sync2: WIDTH must be at least 1");
  end

  // The first stage feeds the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule : cgsc_sync2

// ### rtl/cgsc_fs_latch.sv
// Capture of the frequency-select straps, one-shot unless test mode is set
`timescale 1ns/100ps
module cgsc_fs_latch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pg_n_s,
  input wire logic test_mode_s,
  input wire logic [3:0] fs_s,
  output logic [3:0] fsel_ff,
  output logic locked_ff
);
  import cgsc_pkg::*;

  // After the first low on power-good the straps are frozen unless test mode is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fsel_ff <= RST_FREQ_SEL;
      locked_ff <= 1'b0;
    end else if (!pg_n_s && (!locked_ff || test_mode_s)) begin
      fsel_ff <= fs_s;
      locked_ff <= 1'b1;
    end
  end

  property p_capture;
    @(posedge clk) disable iff (!rst_n)
    (!locked_ff && !pg_n_s) |=> locked_ff && fsel_ff == $past(fs_s);
  endproperty
  a_capture: assert property (p_capture)
    else $error("straps not captured on first power-good low");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    (locked_ff && !test_mode_s) |=> $stable(fsel_ff) && locked_ff;
  endproperty
  a_hold: assert property (p_hold)
    else $error("frequency select changed after lock");
endmodule : cgsc_fs_latch

// ### rtl/cgsc_top.sv
// Serial configuration port and strap latch of the clock generator
//
// Behaviour
// - Frequency straps are captured when power-good is first sampled low.
// - After that capture, later strap and power-good edges are ignored unless test mode is set.
// - Both enable registers load their defaults at reset.
// - Byte write, byte read, block write and block read are served.
// - Blocks run upward from register 0, MSB first, stop after any byte.
// - Slave answers the address byte 11010010 and its read form.
// - Command bit 7: zero means block, one means single byte.
// - Command bits 6..0 give the byte offset; zero for blocks.
// - Block write: address, command, count, data, each acknowledged.
// - The block write count byte is skipped in plain two-wire mode.
// - Block read sends the count first, then data until host NACK.
// - Byte write: address, command, one data byte, each acknowledged.
// - Byte read: command, repeated start, one data byte, host NACK.
// - Differential enable bits: 0 tri-states, 1 enables; reset to 1.
// - Register B bits 6..2 enable the single-ended outputs; reset 1.
`timescale 1ns/100ps
module cgsc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic cpu_power_good_n,
  input wire logic freq_sel_in0,
  input wire logic freq_sel_in1,
  input wire logic freq_sel_in2,
  input wire logic freq_sel_in3,
  input wire logic test_mode,
  input wire logic plain_i2c_mode,
  output logic [3:0] host_freq_sel,
  output logic freq_sel_locked,
  output cgsc_pkg::cgsc_regs_type out_enables
);
  import cgsc_pkg::*;

  logic [1:0] crst_ff;
  logic [1:0] lrst_ff;
  logic rst_n_ff;
  logic lrst_n_ff;
  logic [2:0] lpin_s;
  logic [6:0] cpin_s;
  logic scl_s;
  logic sda_s;
  logic plain_s;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic bus_evt;
  cgsc_state_type st_ff;
  cgsc_phase_type phase_ff;
  logic [2:0] cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [7:0] nb;
  logic [7:0] rd_cur;
  logic full_ff;
  logic ack_ok_ff;
  logic rx_accept;
  logic byte_mode_ff;
  logic done_ff;
  logic [6:0] idx_ff;
  logic sda_oe_ff;
  logic wr_fire;
  logic wr_tgl_ff;
  cgsc_wr_type wr_ff;
  cgsc_regs_type shadow_ff;
  cgsc_regs_type regs_ff;
  logic tgl_seen_ff;
  logic [3:0] fsel_ff;
  logic locked_ff;

  // Asynchronous assert, release through two flip-flops in each domain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crst_ff <= 2'h0;
    end else begin
      crst_ff <= {crst_ff[0], 1'b1};
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lrst_ff <= 2'h0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end

  assign rst_n_ff = crst_ff[1];
  assign lrst_n_ff = lrst_ff[1];

  // Bus pins and mode strap into the link domain
  cgsc_sync2 #(.WIDTH(3), .RST_VAL(3'h6)) u_lsync (
    .clk(link_clk),
    .rst_n(lrst_n_ff),
    .d({scl_in, sda_in, plain_i2c_mode}),
    .q_ff(lpin_s)
  );

  assign scl_s = lpin_s[2];
  assign sda_s = lpin_s[1];
  assign plain_s = lpin_s[0];

  // Straps, test mode and the write toggle into the core domain
  cgsc_sync2 #(.WIDTH(7), .RST_VAL(7'h40)) u_csync (
    .clk(clk),
    .rst_n(rst_n_ff),
    .d({cpu_power_good_n, freq_sel_in3, freq_sel_in2, freq_sel_in1,
        freq_sel_in0, test_mode, wr_tgl_ff}),
    .q_ff(cpin_s)
  );

  cgsc_fs_latch u_fs_latch (
    .clk(clk),
    .rst_n(rst_n_ff),
    .pg_n_s(cpin_s[6]),
    .test_mode_s(cpin_s[1]),
    .fs_s(cpin_s[5:2]),
    .fsel_ff(fsel_ff),
    .locked_ff(locked_ff)
  );

  always_ff @(posedge link_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  assign start = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  assign bus_evt = start || stop;
  assign nb = {rx_ff[6:0], sda_s};

  function automatic logic [7:0] rd_byte(input logic [6:0] i,
                                         input cgsc_regs_type r);
    logic [7:0] v;
    v = UNMAPPED_READ;
    if (i == IDX_REG_A) begin
      v = r.diff_output_enable_a;
    end else if (i == IDX_REG_B) begin
      v = r.misc_output_enable_b;
    end
    return v;
  endfunction : rd_byte

  // Byte the current index would send; a bit of a call cannot be selected
  assign rd_cur = rd_byte(idx_ff, shadow_ff);

  always_comb begin
    case (phase_ff)
      PH_ADDR: rx_accept = (nb[7:1] == SLAVE_ADDR_BYTE[7:1]);
      PH_DATA: rx_accept = !(byte_mode_ff && done_ff);
      default: rx_accept = 1'b1;
    endcase
  end

  // Byte engine; SDA changes only after SCL falls
  always_ff @(posedge link_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      st_ff <= ST_IDLE;
      phase_ff <= PH_ADDR;
      cnt_ff <= 3'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      full_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      byte_mode_ff <= 1'b0;
      done_ff <= 1'b0;
      idx_ff <= IDX_REG_A;
      sda_oe_ff <= 1'b0;
    end else if (stop) begin
      st_ff <= ST_IDLE;
      sda_oe_ff <= 1'b0;
      // A read with no command before it falls back to block mode
      byte_mode_ff <= 1'b0;
    end else if (start) begin
      st_ff <= ST_RX;
      phase_ff <= PH_ADDR;
      cnt_ff <= 3'h0;
      full_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_RX: begin
          if (scl_rise) begin
            rx_ff <= nb;
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'h7) begin
              full_ff <= 1'b1;
              ack_ok_ff <= rx_accept;
            end
          end else if (scl_fall && full_ff) begin
            full_ff <= 1'b0;
            if (ack_ok_ff) begin
              st_ff <= ST_ACK;
              sda_oe_ff <= 1'b1;
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            cnt_ff <= 3'h0;
            st_ff <= ST_RX;
            case (phase_ff)
              PH_ADDR: begin
                if (rx_ff[0]) begin
                  st_ff <= ST_TX;
                  if (byte_mode_ff) begin
                    tx_ff <= rd_cur;
                    sda_oe_ff <= !rd_cur[7];
                    idx_ff <= idx_ff + 7'h01;
                  end else begin
                    tx_ff <= REG_COUNT;
                    sda_oe_ff <= !REG_COUNT[7];
                  end
                end else begin
                  phase_ff <= PH_CMD;
                end
              end
              PH_CMD: begin
                byte_mode_ff <= rx_ff[CMD_BYTE_MODE_BIT];
                idx_ff <= rx_ff[CMD_BYTE_MODE_BIT] ? rx_ff[6:0]
                                                   : IDX_REG_A;
                done_ff <= 1'b0;
                phase_ff <= (rx_ff[CMD_BYTE_MODE_BIT] || plain_s)
                            ? PH_DATA : PH_CNT;
              end
              PH_CNT: begin
                phase_ff <= PH_DATA;
              end
              default: begin
                idx_ff <= idx_ff + 7'h01;
                done_ff <= 1'b1;
              end
            endcase
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == 3'h7) begin
              sda_oe_ff <= 1'b0;
              cnt_ff <= 3'h0;
              st_ff <= ST_MACK;
            end else begin
              cnt_ff <= cnt_ff + 3'h1;
              tx_ff <= {tx_ff[6:0], 1'b0};
              sda_oe_ff <= !tx_ff[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            ack_ok_ff <= !sda_s;
            if (!sda_s) begin
              tx_ff <= rd_cur;
              idx_ff <= idx_ff + 7'h01;
            end
          end else if (scl_fall) begin
            if (ack_ok_ff) begin
              st_ff <= ST_TX;
              sda_oe_ff <= !tx_ff[7];
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign wr_fire = (st_ff == ST_ACK) && (phase_ff == PH_DATA) && scl_fall
                   && !bus_evt;

  // Write word held stable behind a toggle; bytes come far slower than
  // the core domain can take them, so no return handshake is needed
  always_ff @(posedge link_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      wr_ff <= '0;
      wr_tgl_ff <= 1'b0;
      shadow_ff <= RST_REGS;
    end else if (wr_fire) begin
      wr_ff <= '{idx: idx_ff, data: rx_ff};
      wr_tgl_ff <= !wr_tgl_ff;
      if (idx_ff == IDX_REG_A) begin
        shadow_ff.diff_output_enable_a <= rx_ff;
      end else if (idx_ff == IDX_REG_B) begin
        shadow_ff.misc_output_enable_b <= rx_ff;
      end
    end
  end

  // Core-domain registers steering the output enables
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      regs_ff <= RST_REGS;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_seen_ff <= cpin_s[0];
      if (cpin_s[0] != tgl_seen_ff) begin
        if (wr_ff.idx == IDX_REG_A) begin
          regs_ff.diff_output_enable_a <= wr_ff.data;
        end else if (wr_ff.idx == IDX_REG_B) begin
          regs_ff.misc_output_enable_b <= wr_ff.data;
        end
      end
    end
  end

  assign out_enables = regs_ff;
  assign host_freq_sel = fsel_ff;
  assign freq_sel_locked = locked_ff;
  assign sda_oe = sda_oe_ff;
  assign sda_out = 1'b0;

  sequence s_ack_end(cgsc_phase_type ph);
    st_ff == ST_ACK && phase_ff == ph && scl_fall && !bus_evt;
  endsequence

  property p_foreign;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    (st_ff == ST_RX && phase_ff == PH_ADDR && full_ff && !ack_ok_ff
     && scl_fall && !bus_evt) |=> st_ff == ST_IDLE && !sda_oe_ff;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign address was acknowledged");

  property p_ack_drive;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    (st_ff == ST_RX && full_ff && ack_ok_ff && scl_fall && !bus_evt)
    |=> st_ff == ST_ACK && sda_oe_ff;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("accepted byte not acknowledged");

  property p_cnt_skip;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    (s_ack_end(PH_CMD) ##0 !rx_ff[7])
    |=> phase_ff == ($past(plain_s) ? PH_DATA : PH_CNT);
  endproperty
  a_cnt_skip: assert property (p_cnt_skip)
    else $error("count phase wrong for two-wire mode");

  property p_cmd_idx;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    s_ack_end(PH_CMD) |=> byte_mode_ff == $past(rx_ff[7]) &&
      idx_ff == ($past(rx_ff[7]) ? $past(rx_ff[6:0]) : IDX_REG_A);
  endproperty
  a_cmd_idx: assert property (p_cmd_idx)
    else $error("command byte decoded wrongly");

  property p_wr_after_ack;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    $changed(wr_tgl_ff) |-> $past(st_ff) == ST_ACK &&
      $past(phase_ff) == PH_DATA && $past(scl_fall);
  endproperty
  a_wr_after_ack: assert property (p_wr_after_ack)
    else $error("write issued before its acknowledge ended");

  property p_ascend;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    $changed(wr_tgl_ff) |-> idx_ff == $past(idx_ff) + 7'h01;
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("block index did not advance");

  property p_count_first;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    (s_ack_end(PH_ADDR) ##0 (rx_ff[0] && !byte_mode_ff))
    |=> st_ff == ST_TX && tx_ff == REG_COUNT && sda_oe_ff == !REG_COUNT[7];
  endproperty
  a_count_first: assert property (p_count_first)
    else $error("block read did not start with the count");

  property p_msb_first;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    (st_ff == ST_TX && scl_fall && !bus_evt && cnt_ff != 3'h7)
    |=> sda_oe_ff == !$past(tx_ff[6]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("transmit bit order wrong");

  property p_single;
    @(posedge link_clk) disable iff (!lrst_n_ff)
    (st_ff == ST_RX && phase_ff == PH_DATA && byte_mode_ff && done_ff
     && full_ff) |-> !ack_ok_ff;
  endproperty
  a_single: assert property (p_single)
    else $error("second byte of a byte write acknowledged");

  property p_default;
    @(posedge clk) disable iff (!rst_n_ff)
    $rose(rst_n_ff) |-> regs_ff == RST_REGS;
  endproperty
  a_default: assert property (p_default)
    else $error("registers not at defaults after reset");

  property p_apply;
    @(posedge clk) disable iff (!rst_n_ff)
    (cpin_s[0] != tgl_seen_ff && wr_ff.idx == IDX_REG_A)
    |=> regs_ff.diff_output_enable_a == $past(wr_ff.data);
  endproperty
  a_apply: assert property (p_apply)
    else $error("register write not applied");
endmodule : cgsc_top

// ### bench/cgsc_host.sv
// Bus host model driving the two-wire configuration port
`timescale 1ns/100ps
module cgsc_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Quarter bit time; 2500 ns keeps the bus clock at 100 kHz
  int q_ns = 2500;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Also serves as repeated start: data is released before the clock rises
  task automatic start_cond();
    sda_low = 1'b0;
    #(q_ns);
    scl = 1'b1;
    #(q_ns);
    sda_low = 1'b1;
    #(q_ns);
    scl = 1'b0;
    #(q_ns);
  endtask : start_cond

  task automatic stop_cond();
    sda_low = 1'b1;
    #(q_ns);
    scl = 1'b1;
    #(q_ns);
    sda_low = 1'b0;
    #(q_ns);
  endtask : stop_cond

  task automatic bit_out(input logic b);
    sda_low = !b;
    #(q_ns);
    scl = 1'b1;
    #(2 * q_ns);
    scl = 1'b0;
    #(q_ns);
  endtask : bit_out

  // Sampled mid-high, well after the device's data has settled
  task automatic bit_in(output logic b);
    sda_low = 1'b0;
    #(q_ns);
    scl = 1'b1;
    #(q_ns);
    b = sda;
    #(q_ns);
    scl = 1'b0;
    #(q_ns);
  endtask : bit_in

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask : wr_byte

  // The caller passes ack low on the last byte of a read
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(!ack);
  endtask : rd_byte
endmodule : cgsc_host

// ### bench/tb.sv
// Self-checking bench of the clock generator configuration port
`timescale 1ns/100ps
module tb;
  import cgsc_pkg::*;
  logic clk, resetn, link_clk, scl, host_sda_low, sda_out, sda_oe;
  logic pg_n, test_mode, plain_mode, acks_ok, freq_sel_locked;
  logic [3:0] fs, host_freq_sel;
  logic [7:0] d0, d1, d2;
  cgsc_regs_type out_enables;
  int mismatches = 0;
  int checks_done = 0;
  // Open-drain wire with pull-up
  wire sda_wire = !(host_sda_low || (sda_oe && !sda_out));
  // Strap rows: upper nibble applied, lower nibble expected
  logic [7:0] rows [4] = '{8'hAA, 8'h55, 8'hFF, 8'hCC};

  cgsc_top i_cgsc_top (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .cpu_power_good_n(pg_n), .freq_sel_in0(fs[0]), .freq_sel_in1(fs[1]),
    .freq_sel_in2(fs[2]), .freq_sel_in3(fs[3]), .test_mode(test_mode),
    .plain_i2c_mode(plain_mode), .host_freq_sel(host_freq_sel),
    .freq_sel_locked(freq_sel_locked), .out_enables(out_enables));

  cgsc_host i_cgsc_host (.scl(scl), .sda_low(host_sda_low), .sda(sda_wire));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Link clock runs free at an unrelated phase
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
      mismatches++;
    end
  endtask : cmp_bit

  task automatic cmp_vec(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : cmp_vec

  task automatic send(input logic [7:0] d);
    logic a;
    i_cgsc_host.wr_byte(d, a);
    acks_ok = acks_ok & a;
  endtask : send

  // Straps settle before power-good falls; 2 sync stages plus capture
  task automatic pg_cycle(input logic [3:0] straps);
    @(negedge clk) fs = straps;
    pg_n = 1'b1;
    repeat (4) @(negedge clk);
    pg_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask : pg_cycle

  task automatic head(input logic [7:0] cmd);
    acks_ok = 1'b1;
    i_cgsc_host.start_cond();
    send(SLAVE_ADDR_BYTE);
    send(cmd);
  endtask : head

  initial begin
    resetn = 1'b0;
    pg_n = 1'b1;
    fs = 4'h0;
    test_mode = 1'b0;
    plain_mode = 1'b0;
    // Held over several link clock edges as well
    repeat (4) @(posedge link_clk);
    cmp_vec("reset enables", RST_REGS, out_enables);
    cmp_bit("reset lock", 1'b0, freq_sel_locked);
    cmp_bit("reset sda_oe", 1'b0, sda_oe);
    @(negedge clk) resetn = 1'b1;
    repeat (12) @(posedge link_clk);
    pg_cycle(4'h9);
    cmp_vec("strap capture", 16'h0009, {12'h0, host_freq_sel});
    cmp_bit("strap lock", 1'b1, freq_sel_locked);
    pg_cycle(4'h6);
    cmp_vec("strap ignored", 16'h0009, {12'h0, host_freq_sel});
    test_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pg_cycle(rows[i][7:4]);
      cmp_vec("test resample", {12'h0, rows[i][3:0]},
              {12'h0, host_freq_sel});
    end
    test_mode = 1'b0;
    pg_cycle(4'h3);
    cmp_vec("lock after test", 16'h000C, {12'h0, host_freq_sel});
    // Straps changed only during this initial phase
    head(8'h81);
    send(8'h5A);
    cmp_bit("byte write acks", 1'b1, acks_ok);
    // A second data byte in byte mode must be refused
    send(8'h33);
    i_cgsc_host.stop_cond();
    cmp_bit("second byte nack", 1'b0, acks_ok);
    cmp_vec("byte write", {RST_REG_A, 8'h5A}, out_enables);
    head(8'h81);
    i_cgsc_host.start_cond();
    send(SLAVE_ADDR_BYTE | 8'h01);
    i_cgsc_host.rd_byte(1'b0, d0);
    i_cgsc_host.stop_cond();
    cmp_bit("byte read acks", 1'b1, acks_ok);
    cmp_vec("byte read", 16'h005A, {8'h0, d0});
    // Abort inside the data byte
    head(8'h80);
    for (int i = 0; i < 4; i++) i_cgsc_host.bit_out(i[0]);
    i_cgsc_host.stop_cond();
    cmp_vec("partial byte", {RST_REG_A, 8'h5A}, out_enables);
    acks_ok = 1'b1;
    i_cgsc_host.start_cond();
    send(8'hA4);
    i_cgsc_host.stop_cond();
    cmp_bit("foreign ack", 1'b0, acks_ok);
    // Block write with count, stopped after the first data byte
    head(8'h00);
    send(8'h02);
    send(8'hC3);
    i_cgsc_host.stop_cond();
    cmp_bit("block write acks", 1'b1, acks_ok);
    cmp_vec("block early stop", 16'hC35A, out_enables);
    @(negedge clk) plain_mode = 1'b1;
    head(8'h00);
    send(8'h0F);
    send(8'hF0);
    i_cgsc_host.stop_cond();
    @(negedge clk) plain_mode = 1'b0;
    cmp_bit("plain write acks", 1'b1, acks_ok);
    cmp_vec("plain block", 16'h0FF0, out_enables);
    head(8'h00);
    i_cgsc_host.start_cond();
    send(SLAVE_ADDR_BYTE | 8'h01);
    i_cgsc_host.rd_byte(1'b1, d0);
    i_cgsc_host.rd_byte(1'b1, d1);
    i_cgsc_host.rd_byte(1'b0, d2);
    i_cgsc_host.stop_cond();
    cmp_bit("block read acks", 1'b1, acks_ok);
    cmp_vec("block count", {8'h0, REG_COUNT}, {8'h0, d0});
    cmp_vec("block data", 16'h0FF0, {d1, d2});
    cmp_bit("released", 1'b0, sda_oe);
    cmp_bit("sda_out level", 1'b0, sda_out);
    test_done();
  end

  initial begin
    #2600000;
    mismatches++;
    test_done();
  end
endmodule : tb
